// >>> hw/pspwm_defines.vh
// register map, field codes and timing constants of the retrigger pwm unit
`ifndef PSPWM_DEFINES_VH
`define PSPWM_DEFINES_VH
`define PSPWM_OFS_CTRL     6'h00
`define PSPWM_OFS_CONF     6'h04
`define PSPWM_OFS_INCFG    6'h08
`define PSPWM_OFS_SYNC     6'h0C
`define PSPWM_OFS_SET_A    6'h10
`define PSPWM_OFS_RST_A    6'h14
`define PSPWM_OFS_SET_B    6'h18
`define PSPWM_OFS_RST_B    6'h1C
`define PSPWM_OFS_MATRIX   6'h20
`define PSPWM_OFS_CAPTURE  6'h24
`define PSPWM_OFS_STATUS   6'h28
`define PSPWM_RAMP_ONE     2'b00
`define PSPWM_RAMP_TWO     2'b01
`define PSPWM_RAMP_FOUR    2'b10
`define PSPWM_RAMP_CENTER  2'b11
`define PSPWM_MODE_HALT    4'b0111
`define PSPWM_MODE_FIX     4'b1001
`define PSPWM_MODE_FIXOFF  4'b1110
`define PSPWM_DIV1         8'h00
`define PSPWM_DIV4         8'h03
`define PSPWM_DIV16        8'h0F
`define PSPWM_DIV64        8'h3F
`define PSPWM_DIV32        8'h1F
`define PSPWM_DIV256       8'hFF
`define PSPWM_SEL_ZERO     2'b00
`define PSPWM_SEL_ONE      2'b01
`define PSPWM_SEL_TWO      2'b10
`define PSPWM_SEL_THREE    2'b11
`define PSPWM_CNT_ZERO     12'h000
`define PSPWM_CNT_ONE      12'h001
`endif

// >>> hw/pspwm_unit.v
// third power stage pwm unit: retrigger modes, capture, matrix, chain, clock select
`include "pspwm_defines.vh"
module pspwm_unit (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [5:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        pll_clk,
  input  wire        retrig_in_a,
  input  wire        retrig_in_b,
  input  wire        chain_run_in,
  output wire        chain_run_out,
  input  wire        fault_from_prev,
  input  wire        fault_from_next,
  output wire        fault_to_prev,
  output wire        fault_to_next,
  output reg         third_unit_main_out0,
  output reg         third_unit_main_out1,
  output reg         third_unit_extra_out_a,
  output reg         third_unit_extra_out_b,
  output reg         adc_sync_pulse
);
  // software state
  reg        run_bit;
  reg        autorun_from_previous;
  reg [1:0]  clock_prescale_field;
  reg        late_revision;
  reg [1:0]  ramp_mode;
  reg        output_polarity_select;
  reg        clock_source_select;
  reg        matrix_enable;
  reg [3:0]  input_mode_field_a;
  reg        input_active_level_a;
  reg [3:0]  input_mode_field_b;
  reg        input_active_level_b;
  reg [7:0]  sync_output_config;
  reg [11:0] set_a_compare_value;
  reg [11:0] reset_a_compare_value;
  reg [11:0] set_b_compare_value;
  reg [11:0] reset_b_compare_value;
  reg [3:0]  matrix_out0_value;
  reg [3:0]  matrix_out1_value;
  reg [11:0] event_capture_value;
  reg        reload_flag;
  reg        capture_flag;
  reg        sync_error_flag;
  // waveform state
  reg [11:0] count;
  reg        count_down;
  reg [1:0]  ramp;
  reg [7:0]  presc;
  reg        kill_a;
  reg        kill_b;
  reg [1:0]  sync_a;
  reg [1:0]  sync_b;
  reg [2:0]  sync_pll;
  reg        act_a_d;
  reg        act_b_d;
  reg        run_d;
  reg        chain_d;
  reg        wave0_d;
  reg        wave1_d;
  reg [7:0]  div_limit;

  wire setup   = psel & ~penable;
  wire wr_acc  = psel & penable & pwrite;
  wire mapped  = (paddr[1:0] == 2'b00) && (paddr <= `PSPWM_OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // effective run: own bit or previous unit's run when autorun is set
  wire run_eff = run_bit | (autorun_from_previous & chain_run_in);
  assign chain_run_out = run_eff;

  // two-stage pin synchronisers; the pll pin keeps a third stage for its edge
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a   <= 2'b00;
      sync_b   <= 2'b00;
      sync_pll <= 3'b000;
    end else begin
      sync_a   <= {sync_a[0], retrig_in_a};
      sync_b   <= {sync_b[0], retrig_in_b};
      sync_pll <= {sync_pll[1:0], pll_clk};
    end
  end

  // active level per input, polarity from the level bit
  wire act_a  = input_active_level_a ? sync_a[1] : ~sync_a[1];
  wire act_b  = input_active_level_b ? sync_b[1] : ~sync_b[1];
  wire edge_a = act_a & ~act_a_d;
  wire edge_b = act_b & ~act_b_d;

  // clock source and prescale divider
  wire src_tick = clock_source_select ? (sync_pll[1] & ~sync_pll[2]) : 1'b1;
  always @* begin
    case (clock_prescale_field)
      `PSPWM_SEL_ZERO: div_limit = `PSPWM_DIV1;
      `PSPWM_SEL_ONE:  div_limit = `PSPWM_DIV4;
      `PSPWM_SEL_TWO:  div_limit = late_revision ? `PSPWM_DIV32 : `PSPWM_DIV16;
      default:         div_limit = late_revision ? `PSPWM_DIV256 : `PSPWM_DIV64;
    endcase
  end
  wire tick = run_eff & src_tick & (presc == div_limit);

  // compare windows
  wire centered = (ramp_mode == `PSPWM_RAMP_CENTER);
  wire win_a = (count >= set_a_compare_value) && (count < reset_a_compare_value);
  wire win_b = (count >= set_b_compare_value) && (count < reset_b_compare_value);
  reg  raw0;
  reg  raw1;
  always @* begin
    case (ramp_mode)
      `PSPWM_RAMP_ONE: begin
        raw0 = win_a;
        raw1 = win_b;
      end
      `PSPWM_RAMP_TWO: begin
        raw0 = win_a & ~ramp[0];
        raw1 = win_b & ramp[0];
      end
      `PSPWM_RAMP_FOUR: begin
        raw0 = win_a & ~ramp[1];
        raw1 = win_b & ramp[1];
      end
      default: begin
        raw0 = (count >= set_a_compare_value);
        raw1 = (count < set_b_compare_value);
      end
    endcase
  end
  wire at_top  = (count == reset_b_compare_value);
  wire at_zero = (count == `PSPWM_CNT_ZERO);
  wire wrap    = tick & (centered ? (count_down & (at_zero | (count == `PSPWM_CNT_ONE)))
                                  : at_top);

  // retrigger acceptance: fixed modes only inside the matching on-time, halt at any time
  wire fixed_a = (input_mode_field_a == `PSPWM_MODE_FIX) |
                 (input_mode_field_a == `PSPWM_MODE_FIXOFF);
  wire fixed_b = (input_mode_field_b == `PSPWM_MODE_FIX) |
                 (input_mode_field_b == `PSPWM_MODE_FIXOFF);
  wire acc_a   = edge_a & fixed_a & raw0;
  wire acc_b   = edge_b & fixed_b & raw1;
  wire halt_a  = edge_a & (input_mode_field_a == `PSPWM_MODE_HALT);
  wire halt_b  = edge_b & (input_mode_field_b == `PSPWM_MODE_HALT);
  wire own_halt = halt_a | halt_b;
  // halt faults only travel the chain; slave reports to its run source
  assign fault_to_prev = own_halt & autorun_from_previous;
  assign fault_to_next = own_halt;
  wire halt_any = own_halt | fault_from_prev | fault_from_next;
  wire any_event = acc_a | acc_b | own_halt;

  // counter, direction and ramp index; restart aligned on run start
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count      <= `PSPWM_CNT_ZERO;
      count_down <= 1'b0;
      ramp       <= 2'b00;
      presc      <= `PSPWM_DIV1;
      run_d      <= 1'b0;
    end else begin
      run_d <= run_eff;
      if (!run_eff) begin
        count      <= `PSPWM_CNT_ZERO;
        count_down <= 1'b0;
        ramp       <= 2'b00;
        presc      <= `PSPWM_DIV1;
      end else begin
        if (src_tick)
          presc <= (presc == div_limit) ? `PSPWM_DIV1 : presc + 8'h01;
        if (tick) begin
          // retrigger never changes period: frequency stays fixed
          if (centered) begin
            if (!count_down && at_top)
              count_down <= 1'b1;
            else if (count_down && (at_zero | (count == `PSPWM_CNT_ONE))) begin
              count_down <= 1'b0;
              count      <= `PSPWM_CNT_ZERO;
            end else if (count_down)
              count <= count - 12'h001;
            else
              count <= count + 12'h001;
          end else if (at_top) begin
            count <= `PSPWM_CNT_ZERO;
            ramp  <= ramp + 2'b01;
          end else
            count <= count + 12'h001;
        end
      end
    end
  end

  // output kill flags for the fixed frequency modes
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      kill_a  <= 1'b0;
      kill_b  <= 1'b0;
      act_a_d <= 1'b0;
      act_b_d <= 1'b0;
    end else begin
      act_a_d <= act_a;
      act_b_d <= act_b;
      if (acc_a)
        kill_a <= 1'b1;
      else if (input_mode_field_a == `PSPWM_MODE_FIXOFF)
        kill_a <= kill_a & act_a;
      else if (wrap | ~run_eff)
        kill_a <= 1'b0;
      if (acc_b)
        kill_b <= 1'b1;
      else if (input_mode_field_b == `PSPWM_MODE_FIXOFF)
        kill_b <= kill_b & act_b;
      else if (wrap | ~run_eff)
        kill_b <= 1'b0;
    end
  end

  // waveform after kill, then polarity or matrix
  wire wave0 = raw0 & ~kill_a & run_eff;
  wire wave1 = raw1 & ~kill_b & run_eff;
  wire use_matrix = matrix_enable & (ramp_mode == `PSPWM_RAMP_FOUR);
  wire next_out0 = use_matrix ? (run_eff & matrix_out0_value[ramp])
                              : (wave0 ^ ~output_polarity_select);
  wire next_out1 = use_matrix ? (run_eff & matrix_out1_value[ramp])
                              : (wave1 ^ ~output_polarity_select);
  wire psync_edge = sync_output_config[5] ? (wave1 ^ wave1_d) : (wave0 ^ wave0_d);
  wire psync_rise = sync_output_config[5] ? wave1 : wave0;
  wire ra_match   = tick & (count == reset_a_compare_value);
  reg  next_adc;
  always @* begin
    if (centered)
      next_adc = ~sync_output_config[5] & ra_match &
                 (count_down ^ sync_output_config[4]);
    else
      next_adc = psync_edge & (psync_rise ^ sync_output_config[4]);
  end

  // registered output pins; extra outputs follow the selectors
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      third_unit_main_out0   <= 1'b0;
      third_unit_main_out1   <= 1'b0;
      third_unit_extra_out_a <= 1'b0;
      third_unit_extra_out_b <= 1'b0;
      adc_sync_pulse         <= 1'b0;
      wave0_d                <= 1'b0;
      wave1_d                <= 1'b0;
    end else begin
      wave0_d                <= wave0;
      wave1_d                <= wave1;
      third_unit_main_out0   <= next_out0;
      third_unit_main_out1   <= next_out1;
      third_unit_extra_out_a <= sync_output_config[6] ? next_out1 : next_out0;
      third_unit_extra_out_b <= sync_output_config[7] ? next_out0 : next_out1;
      adc_sync_pulse         <= next_adc;
    end
  end

  // register writes, capture and status flags
  wire clr_wr = wr_acc & (paddr == `PSPWM_OFS_STATUS);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_bit                <= 1'b0;
      autorun_from_previous  <= 1'b0;
      clock_prescale_field   <= 2'b00;
      late_revision          <= 1'b0;
      ramp_mode              <= `PSPWM_RAMP_ONE;
      output_polarity_select <= 1'b0;
      clock_source_select    <= 1'b0;
      matrix_enable          <= 1'b0;
      input_mode_field_a     <= 4'h0;
      input_active_level_a   <= 1'b0;
      input_mode_field_b     <= 4'h0;
      input_active_level_b   <= 1'b0;
      sync_output_config     <= 8'h00;
      set_a_compare_value    <= `PSPWM_CNT_ZERO;
      reset_a_compare_value  <= `PSPWM_CNT_ZERO;
      set_b_compare_value    <= `PSPWM_CNT_ZERO;
      reset_b_compare_value  <= `PSPWM_CNT_ZERO;
      matrix_out0_value      <= 4'h0;
      matrix_out1_value      <= 4'h0;
      event_capture_value    <= `PSPWM_CNT_ZERO;
      reload_flag            <= 1'b0;
      capture_flag           <= 1'b0;
      sync_error_flag        <= 1'b0;
      chain_d                <= 1'b0;
    end else begin
      chain_d <= chain_run_in;
      if (wr_acc) begin
        case (paddr)
          `PSPWM_OFS_CTRL: begin
            run_bit               <= pwdata[0];
            autorun_from_previous <= pwdata[1];
            clock_prescale_field  <= pwdata[3:2];
            late_revision         <= pwdata[4];
          end
          `PSPWM_OFS_CONF: begin
            ramp_mode              <= pwdata[1:0];
            output_polarity_select <= pwdata[2];
            clock_source_select    <= pwdata[3];
            matrix_enable          <= pwdata[4];
          end
          `PSPWM_OFS_INCFG: begin
            input_mode_field_a   <= pwdata[3:0];
            input_active_level_a <= pwdata[4];
            input_mode_field_b   <= pwdata[11:8];
            input_active_level_b <= pwdata[12];
          end
          `PSPWM_OFS_SYNC:   sync_output_config    <= pwdata[7:0];
          `PSPWM_OFS_SET_A:  set_a_compare_value   <= pwdata[11:0];
          `PSPWM_OFS_RST_A:  reset_a_compare_value <= pwdata[11:0];
          `PSPWM_OFS_SET_B:  set_b_compare_value   <= pwdata[11:0];
          `PSPWM_OFS_RST_B:  reset_b_compare_value <= pwdata[11:0];
          `PSPWM_OFS_MATRIX: begin
            matrix_out0_value <= pwdata[3:0];
            matrix_out1_value <= pwdata[7:4];
          end
          default: ;
        endcase
      end
      // halt fault clears run; it wins over a write in the same cycle
      if (halt_any)
        run_bit <= 1'b0;
      if (any_event)
        event_capture_value <= count;
      // flags: set wins over the write-one clear
      reload_flag     <= (wrap & ramp_mode != `PSPWM_RAMP_CENTER) |
                         (wrap & centered) |
                         (reload_flag & ~(clr_wr & pwdata[0]));
      capture_flag    <= any_event | (capture_flag & ~(clr_wr & pwdata[1]));
      sync_error_flag <= (autorun_from_previous & chain_d & ~chain_run_in & run_bit) |
                         (sync_error_flag & ~(clr_wr & pwdata[2]));
    end
  end

  // read data captured during setup, presented in the access phase
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (setup) begin
      case (paddr)
        `PSPWM_OFS_CTRL:    prdata <= {27'h000_0000, late_revision, clock_prescale_field,
                                       autorun_from_previous, run_bit};
        `PSPWM_OFS_CONF:    prdata <= {27'h000_0000, matrix_enable, clock_source_select,
                                       output_polarity_select, ramp_mode};
        `PSPWM_OFS_INCFG:   prdata <= {19'h0_0000, input_active_level_b, input_mode_field_b,
                                       3'b000, input_active_level_a, input_mode_field_a};
        `PSPWM_OFS_SYNC:    prdata <= {24'h00_0000, sync_output_config};
        `PSPWM_OFS_SET_A:   prdata <= {20'h0_0000, set_a_compare_value};
        `PSPWM_OFS_RST_A:   prdata <= {20'h0_0000, reset_a_compare_value};
        `PSPWM_OFS_SET_B:   prdata <= {20'h0_0000, set_b_compare_value};
        `PSPWM_OFS_RST_B:   prdata <= {20'h0_0000, reset_b_compare_value};
        `PSPWM_OFS_MATRIX:  prdata <= {24'h00_0000, matrix_out1_value, matrix_out0_value};
        `PSPWM_OFS_CAPTURE: prdata <= {20'h0_0000, event_capture_value};
        `PSPWM_OFS_STATUS:  prdata <= {4'h0, count, 12'h000, run_eff,
                                       sync_error_flag, capture_flag, reload_flag};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> verification/pspwm_load.sv
// behavioural power switches and adc sample-hold, counting what reaches them
module pspwm_load (
  input  logic       sys_clk,
  input  logic [4:0] pins,
  output int         seen [5]
);
  timeunit 1ns;
  timeprecision 1ns;
  // non-blocking start value, so every write to the counters is of one kind
  initial foreach (seen[i]) seen[i] <= 0;
  // gates 0..3 add on-cycles, bit 4 is the sample strobe; unknown never counts
  always @(posedge sys_clk) begin
    foreach (seen[i]) seen[i] <= seen[i] + int'(pins[i] === 1'b1);
  end
endmodule

// >>> verification/pspwm_unit_asserts.sv
// port-level checker of the retrigger pwm unit, bound to its top module
`include "pspwm_defines.vh"
module pspwm_chk (
  input logic        sys_clk,
  input logic        arst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [5:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        chain_run_in,
  input logic        chain_run_out,
  input logic        fault_to_prev,
  input logic        fault_to_next,
  input logic        third_unit_main_out0,
  input logic        third_unit_main_out1,
  input logic        third_unit_extra_out_a,
  input logic        third_unit_extra_out_b,
  input logic        adc_sync_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sel_a, sel_b, auto_run;
  logic [1:0] quiet;
  wire        wr_acc = psel && penable && pwrite && pready;
  wire        bad    = paddr[1:0] != 2'h0 || paddr > `PSPWM_OFS_STATUS;

  // shadows of written bits; quiet covers the registered lag after a selector write
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sel_a, sel_b, auto_run} <= 3'h0;
      quiet <= 2'h0;
    end else begin
      if (quiet != 2'h3) quiet <= quiet + 2'h1;
      if (wr_acc && paddr == `PSPWM_OFS_SYNC) begin
        {sel_b, sel_a} <= pwdata[7:6];
        quiet <= 2'h0;
      end
      if (wr_acc && paddr == `PSPWM_OFS_CTRL) auto_run <= pwdata[1];
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence acc_s; psel && penable; endsequence
  sequence pulse_s(s); s ##1 !s; endsequence

  ready_access_a: assert property (acc_s |-> pready) else $error("access without ready");
  unmapped_err_a: assert property (acc_s ##0 bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_s ##0 !bad |-> !pslverr) else $error("mapped access refused");
  extra_a_copy_a: assert property (quiet[1] |->
    third_unit_extra_out_a == (sel_a ? third_unit_main_out1 : third_unit_main_out0))
    else $error("extra output a wrong source");
  extra_b_copy_a: assert property (quiet[1] |->
    third_unit_extra_out_b == (sel_b ? third_unit_main_out0 : third_unit_main_out1))
    else $error("extra output b wrong source");
  adc_pulse_a: assert property (adc_sync_pulse |-> pulse_s(adc_sync_pulse))
    else $error("adc sync longer than one cycle");
  autorun_follow_a: assert property (auto_run && chain_run_in |-> chain_run_out)
    else $error("autorun unit not started with previous");
  halt_pair_a: assert property (fault_to_prev |-> fault_to_next)
    else $error("halt sent back without own halt");
  halt_pulse_a: assert property (fault_to_next |-> pulse_s(fault_to_next))
    else $error("halt pulse longer than one cycle");
endmodule

bind pspwm_unit pspwm_chk u_chk (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .chain_run_in, .chain_run_out, .fault_to_prev,
  .fault_to_next, .third_unit_main_out0, .third_unit_main_out1, .third_unit_extra_out_a,
  .third_unit_extra_out_b, .adc_sync_pulse);

// >>> verification/test_power_stage_pwm_retrigger_sync_clock.sv
// self-checking bench of the retrigger pwm unit
`include "pspwm_defines.vh"
module test_power_stage_pwm_retrigger_sync_clock;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, arst_n, psel, penable, pwrite, pll_clk, err;
  logic        retrig_in_a, retrig_in_b, chain_run_in, fault_from_prev, fault_from_next;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic        pready, pslverr, chain_run_out, fault_to_prev, fault_to_next, adc_sync_pulse;
  logic        third_unit_main_out0, third_unit_main_out1;
  logic        third_unit_extra_out_a, third_unit_extra_out_b;
  int          cnt [5], num_errors = 0, compares = 0, cyc = 0, fp, fn, k;
  int          ctrl_q [7] = '{1, 5, 9, 13, 25, 29, 1};
  int          div_q [7]  = '{1, 4, 16, 64, 32, 256, 4};
  int          wave [4]   = '{2, 12, 8, 15};

  pspwm_unit dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pll_clk, .retrig_in_a, .retrig_in_b, .chain_run_in, .chain_run_out,
    .fault_from_prev, .fault_from_next, .fault_to_prev, .fault_to_next,
    .third_unit_main_out0, .third_unit_main_out1, .third_unit_extra_out_a,
    .third_unit_extra_out_b, .adc_sync_pulse);
  pspwm_load load (.sys_clk, .seen(cnt), .pins({adc_sync_pulse, third_unit_extra_out_b,
    third_unit_extra_out_a, third_unit_main_out1, third_unit_main_out0}));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // pll pin at a quarter of the system rate; timeout sized for the prescale sweep
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pll_clk <= cyc[1];
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // stop first so the counter restarts from zero
  task automatic setup(input logic [31:0] ctrl, conf, inp);
    apb(1'b1, `PSPWM_OFS_CTRL, 0);
    apb(1'b1, `PSPWM_OFS_CONF, conf);
    apb(1'b1, `PSPWM_OFS_INCFG, inp);
    apb(1'b1, `PSPWM_OFS_CTRL, ctrl);
  endtask
  // model: on-cycles seen in n cycles of whole periods of per ticks
  function automatic int on_cyc(int n, lo, hi, per, div);
    return n / (per * div) * (hi - lo) * div;
  endfunction
  // counts at the load over n cycles; -1 leaves a column unchecked
  task automatic expect_on(input int n, input int e [5]);
    int s [5];
    s = cnt;
    repeat (n) @(posedge sys_clk);
    foreach (s[i]) if (e[i] >= 0) check(cnt[i] - s[i], e[i]);
  endtask
  task automatic wait_out0(input logic v);
    for (int i = 0; i < 40 && third_unit_main_out0 !== v; i++) @(posedge sys_clk);
    check(third_unit_main_out0, v);
  endtask

  initial begin
    {arst_n, psel, penable, pwrite, retrig_in_a, retrig_in_b} <= 6'h0;
    {chain_run_in, fault_from_prev, fault_from_next} <= 3'h0;
    paddr <= 6'h0;
    pwdata <= 32'h0;
    void'($urandom(32'ha089));
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    // reset state, refused places, read-only capture, random compare value
    apb(1'b0, `PSPWM_OFS_STATUS, 0);
    check(rd, 0);
    apb(1'b1, 6'h02, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b1, `PSPWM_OFS_CAPTURE, 32'hFFFF_FFFF);
    apb(1'b0, `PSPWM_OFS_CAPTURE, 0);
    check(rd, 0);
    r = ($urandom % 4095) + 1;
    apb(1'b1, `PSPWM_OFS_RST_A, r);
    apb(1'b0, `PSPWM_OFS_RST_A, 0);
    check(rd, r);
    for (k = 0; k < 4; k++) apb(1'b1, 6'(`PSPWM_OFS_SET_A + 4 * k), wave[k]);
    setup(1, 4, 0);
    // every selector and adc source pairing, one ramp, 16-cycle period
    for (k = 0; k < 4; k++) begin
      apb(1'b1, `PSPWM_OFS_SYNC, k * 80);
      repeat (4) @(posedge sys_clk);
      expect_on(64, '{40, 28, k[0] ? 28 : 40, k[1] ? 40 : 28, 4});
    end
    // prescale codes, late revision, pll source
    for (k = 0; k < 7; k++) begin
      setup(ctrl_q[k], k == 6 ? 12 : 4, 0);
      repeat (32 * div_q[k] + 16) @(posedge sys_clk);
      expect_on(64 * div_q[k], '{on_cyc(64 * div_q[k], 2, 12, 16, div_q[k]), -1, -1, -1, -1});
    end
    // matrix in four ramps, both polarities give the same pins
    apb(1'b1, `PSPWM_OFS_MATRIX, 32'h71);
    for (k = 0; k < 2; k++) begin
      setup(1, k ? 32'h16 : 32'h12, 0);
      repeat (70) @(posedge sys_clk);
      expect_on(128, '{32, 96, -1, -1, -1});
    end
    // mode 9 rising edge in on-time kills only until the wrap
    setup(1, 4, 32'h19);
    wait_out0(1'b1);
    retrig_in_a <= 1'b1;
    repeat (7) @(posedge sys_clk);
    check(third_unit_main_out0, 1'b0);
    repeat (16) @(posedge sys_clk);
    expect_on(64, '{40, -1, -1, -1, -1});
    apb(1'b0, `PSPWM_OFS_STATUS, 0);
    check(rd[1], 1'b1);
    apb(1'b0, `PSPWM_OFS_CAPTURE, 0);
    check(rd >= 2 && rd < 12, 1'b1);
    // an edge in off-time is ignored
    retrig_in_a <= 1'b0;
    wait_out0(1'b1);
    wait_out0(1'b0);
    retrig_in_a <= 1'b1;
    // window opens on the ramp the edge lands in, so a wrong kill would cost on-cycles
    repeat (4) @(posedge sys_clk);
    expect_on(64, '{40, -1, -1, -1, -1});
    // level bit clear: falling edge is the significant one
    apb(1'b1, `PSPWM_OFS_INCFG, 32'h09);
    wait_out0(1'b0);
    wait_out0(1'b1);
    retrig_in_a <= 1'b0;
    repeat (7) @(posedge sys_clk);
    check(third_unit_main_out0, 1'b0);
    // mode 14 low-active: off while low, period kept after release
    apb(1'b1, `PSPWM_OFS_INCFG, 32'h0E);
    repeat (8) @(posedge sys_clk);
    expect_on(64, '{0, -1, -1, -1, -1});
    retrig_in_a <= 1'b1;
    repeat (16) @(posedge sys_clk);
    expect_on(64, '{40, -1, -1, -1, -1});
    // mode 7 halt on input b travels both ways along the chain
    setup(3, 4, 32'h1700);
    {fp, fn} = 0;
    retrig_in_b <= 1'b1;
    repeat (10) begin
      @(posedge sys_clk);
      fp += int'(fault_to_prev === 1'b1);
      fn += int'(fault_to_next === 1'b1);
    end
    check(fp, 1);
    check(fn, 1);
    check(chain_run_out, 1'b0);
    chain_run_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(chain_run_out, 1'b1);
    chain_run_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(chain_run_out, 1'b0);
    apb(1'b1, `PSPWM_OFS_CTRL, 1);
    fault_from_prev <= 1'b1;
    @(posedge sys_clk);
    fault_from_prev <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(chain_run_out, 1'b0);
    // centered: reset-a match drives the adc point, source 1x gives none
    apb(1'b1, `PSPWM_OFS_SYNC, 32'h20);
    setup(1, 7, 0);
    repeat (40) @(posedge sys_clk);
    expect_on(128, '{-1, -1, -1, -1, 0});
    apb(1'b1, `PSPWM_OFS_SYNC, 0);
    fp = cnt[4];
    repeat (128) @(posedge sys_clk);
    check(cnt[4] - fp >= 3, 1'b1);
    report_and_stop();
  end
endmodule
